/* logic/bbm_overlap.sv */
// Purpose: Fixed overlap decode used when the access width is ignored.
// Assumes: Inputs are stable within the watched cycle.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bbm_overlap (
   input wire logic [1:0] prog_low_i, // Programmed low address bits
   input wire logic [1:0] cyc_low_i, // Cycle low address bits
   input wire logic [1:0] width_i, // Cycle width code
   output logic hit_o // Programmed location is touched
);
   always_comb
   begin
      hit_o = 1'b0;
      case (prog_low_i)
         2'h0: hit_o = (cyc_low_i == 2'h0);
         2'h1:
         begin
            if (cyc_low_i == 2'h0)
            begin
               hit_o = (width_i != bbm_pkg::WID_BYTE);
            end
            else
            begin
               hit_o = 1'b1;
            end
         end
         2'h2:
         begin
            case (cyc_low_i)
               2'h0: hit_o = (width_i == bbm_pkg::WID_LONG) || (width_i == bbm_pkg::WID_TRIPLE);
               2'h1: hit_o = (width_i != bbm_pkg::WID_BYTE);
               2'h2: hit_o = 1'b1;
               default: hit_o = 1'b0;
            endcase
         end
         default:
         begin
            // Offset three: only widths that reach the last byte
            case (cyc_low_i)
               2'h0: hit_o = (width_i == bbm_pkg::WID_LONG);
               2'h1: hit_o = (width_i == bbm_pkg::WID_LONG) || (width_i == bbm_pkg::WID_TRIPLE);
               2'h2: hit_o = (width_i != bbm_pkg::WID_BYTE);
               default: hit_o = 1'b1;
            endcase
         end
      endcase
   end
endmodule // bbm_overlap

/* logic/bbm_pkg.sv */
// Purpose: Shared constants for the bus breakpoint matcher.
// Assumes: 32-bit classic Wishbone register port, byte addresses.
// Notes: Field positions follow the match control register layout.
package bbm_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   localparam logic [7:0] OPTION_OFS = 8'h10;
   localparam logic [7:0] LIVE_OFS = 8'h14;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_VALID_BIT = 0;
   localparam int CTRL_SPACE_LSB = 1;
   localparam int CTRL_SPACE_MSB = 9;
   localparam int CTRL_BLK_LSB = 10;
   localparam int CTRL_BLK_MSB = 11;
   localparam int CTRL_INV_BIT = 12;
   localparam int CTRL_WIDTH_LSB = 13;
   localparam int CTRL_WIDTH_MSB = 14;
   localparam int CTRL_IGN_BIT = 15;
   localparam int CTRL_DIR_LSB = 16;
   localparam int CTRL_DIR_MSB = 17;
   localparam int CTRL_BUS_BIT = 18;
   localparam logic [31:0] CTRL_WR_MASK = 32'h000f_ffff;
   localparam int OPT_TT_BIT = 0;
   localparam int IRQ_BREAK_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic IRQ_RESET = 1'b0;
   localparam logic OPT_RESET = 1'b0;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] DIR_READ = 2'h0;
   localparam logic [1:0] DIR_WRITE = 2'h1;
   localparam logic [1:0] DIR_BOTH = 2'h2;
   localparam logic [1:0] WID_LONG = 2'h0;
   localparam logic [1:0] WID_BYTE = 2'h1;
   localparam logic [1:0] WID_WORD = 2'h2;
   localparam logic [1:0] WID_TRIPLE = 2'h3;
   localparam logic [1:0] BLK_FULL = 2'h0;
   localparam logic [1:0] BLK_2K = 2'h1;
   localparam logic [1:0] BLK_8K = 2'h2;
   localparam logic [1:0] BLK_32K = 2'h3;
   localparam logic [31:0] BLK_2K_MASK = 32'hffff_f800;
   localparam logic [31:0] BLK_8K_MASK = 32'hffff_e000;
   localparam logic [31:0] BLK_32K_MASK = 32'hffff_8000;
   localparam logic [31:0] LOW2_MASK = 32'hffff_fffc;
   localparam logic [31:0] FULL_MASK = 32'hffff_ffff;
   localparam logic [3:0] SPACE_DMA_IDX = 4'h8;
   localparam logic [3:0] SPACE_ACK_IDX = 4'h7;
   localparam logic [1:0] KIND_NORMAL = 2'h0;
   localparam logic [1:0] KIND_ACK = 2'h3;
   localparam logic [2:0] MOD_NONE = 3'h7;

   typedef enum logic [1:0] {
      BBM_BUS_IDLE = 2'b00,
      BBM_BUS_ACK = 2'b01
   } bbm_bus_e;
endpackage

/* logic/bbm_top.sv */
// Purpose: Breakpoint matcher watching internal or external bus cycles.
// Assumes: Watched bus inputs synchronous to clk_i; Wishbone classic slave.
// Notes: Break request is registered, so it trails the cycle by one clock.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Direction code: 00 reads, 01 writes, 10 both; 11 never matches.
// - Width-ignore clear: cycle width must equal the programmed width code.
// - Width-ignore set: break when accessed bytes overlap the programmed location; offset 01 also hits any cycle at 10 or 11.
// - Width codes: 00 long, 01 byte, 10 word, 11 three bytes.
// - Exact width compare only with full-address matching selected.
// - Overlap decode from low address bits and width; offset 00 hits only 00.
// - Programmed offset 11 hits per fixed decode, never bytes elsewhere.
// - Invert with block mask: break on addresses outside the block.
// - Invert ignored with full-address matching.
// - Block size excludes bits 10:0, 12:0 or 14:0, or none.
// - Space exclude bit set blocks matches for its function code.
// - Space exclude bit clear allows matches in that space.
// - Transfer-kind cycles: bit 7 acknowledge, bits 6:0 modifiers, bit 8 unused.
// - No break unless the contents-valid bit is set.
// - The full 32-bit programmed address is the compare value.
// - External bus: low two bits excluded, width treated as ignored.
// - Reset clears every control field, disabling matching.
module bbm_top (
   input wire logic clk_i, // System clock, 40 MHz
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire logic int_cyc_i, // Internal bus cycle active
   input wire logic [31:0] int_addr_i, // Internal bus address
   input wire logic int_write_i, // Internal bus write
   input wire logic [1:0] int_width_i, // Internal bus width code
   input wire logic [3:0] int_fc_i, // Internal bus function code
   input wire logic ext_cyc_i, // External bus cycle active
   input wire logic [31:0] ext_addr_i, // External bus address
   input wire logic ext_write_i, // External bus write
   input wire logic [1:0] ext_width_i, // External bus width code
   input wire logic [3:0] ext_fc_i, // External bus function code
   input wire logic [1:0] ext_kind_i, // External transfer kind
   input wire logic [2:0] ext_mod_i, // External transfer modifier
   output logic break_request_o, // Break request, active high
   output logic irq_o // Interrupt, level, active high
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] match_address_reg_q;
   logic [31:0] match_control_reg_q;
   logic tt_style_q;
   logic irq_stat_q;
   logic irq_stat_d;
   logic irq_mask_q;
   logic irq_mask_d;
   logic irq_q;
   logic break_q;
   logic ack_q;
   logic [31:0] rdata_q;
   bbm_pkg::bbm_bus_e bus_q;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   logic ctrl_valid;
   logic [8:0] space_exclude_bits;
   logic [1:0] block_size_sel;
   logic invert_block_match;
   logic [1:0] width_code;
   logic ignore_access_width;
   logic [1:0] cycle_dir_sel;
   logic internal_bus;

   assign ctrl_valid = match_control_reg_q[bbm_pkg::CTRL_VALID_BIT];
   assign space_exclude_bits = match_control_reg_q[bbm_pkg::CTRL_SPACE_MSB:bbm_pkg::CTRL_SPACE_LSB];
   assign block_size_sel = match_control_reg_q[bbm_pkg::CTRL_BLK_MSB:bbm_pkg::CTRL_BLK_LSB];
   assign invert_block_match = match_control_reg_q[bbm_pkg::CTRL_INV_BIT];
   assign width_code = match_control_reg_q[bbm_pkg::CTRL_WIDTH_MSB:bbm_pkg::CTRL_WIDTH_LSB];
   assign ignore_access_width = match_control_reg_q[bbm_pkg::CTRL_IGN_BIT];
   assign cycle_dir_sel = match_control_reg_q[bbm_pkg::CTRL_DIR_MSB:bbm_pkg::CTRL_DIR_LSB];
   assign internal_bus = !match_control_reg_q[bbm_pkg::CTRL_BUS_BIT];

   // ----------------------------------------------------------------
   // Watched bus selection
   // ----------------------------------------------------------------
   logic w_cyc;
   logic [31:0] w_addr;
   logic w_write;
   logic [1:0] w_width;
   logic [3:0] w_fc;

   assign w_cyc = internal_bus ? int_cyc_i : ext_cyc_i;
   assign w_addr = internal_bus ? int_addr_i : ext_addr_i;
   assign w_write = internal_bus ? int_write_i : ext_write_i;
   assign w_width = internal_bus ? int_width_i : ext_width_i;
   assign w_fc = internal_bus ? int_fc_i : ext_fc_i;

   // ----------------------------------------------------------------
   // Match decision
   // ----------------------------------------------------------------
   logic ignore_eff;
   logic [31:0] cmp_mask;
   logic addr_hit;
   logic addr_term;
   logic overlap_hit;
   logic width_ok;
   logic dir_ok;
   logic [3:0] space_idx;
   logic space_has_bit;
   logic space_ok;
   logic match;

   // External bus has no meaningful low address bits for sizing
   assign ignore_eff = ignore_access_width || !internal_bus;

   always_comb
   begin
      case (block_size_sel)
         bbm_pkg::BLK_2K: cmp_mask = bbm_pkg::BLK_2K_MASK;
         bbm_pkg::BLK_8K: cmp_mask = bbm_pkg::BLK_8K_MASK;
         bbm_pkg::BLK_32K: cmp_mask = bbm_pkg::BLK_32K_MASK;
         default: cmp_mask = ignore_eff ? bbm_pkg::LOW2_MASK : bbm_pkg::FULL_MASK;
      endcase
   end

   assign addr_hit = ((w_addr ^ match_address_reg_q) & cmp_mask) == 32'h0000_0000;
   // Inversion only ever applies to a masked block compare
   assign addr_term = ((block_size_sel != bbm_pkg::BLK_FULL) && invert_block_match) ? !addr_hit : addr_hit;

   bbm_overlap u_overlap (
      .prog_low_i(match_address_reg_q[1:0]),
      .cyc_low_i(w_addr[1:0]),
      .width_i(w_width),
      .hit_o(overlap_hit)
   );

   always_comb
   begin
      if (block_size_sel != bbm_pkg::BLK_FULL)
      begin
         width_ok = 1'b1;
      end
      else if (ignore_eff)
      begin
         width_ok = overlap_hit;
      end
      else
      begin
         // Low bits already compared exactly through the address
         width_ok = (w_width == width_code);
      end
   end

   always_comb
   begin
      case (cycle_dir_sel)
         bbm_pkg::DIR_READ: dir_ok = !w_write;
         bbm_pkg::DIR_WRITE: dir_ok = w_write;
         bbm_pkg::DIR_BOTH: dir_ok = 1'b1;
         default: dir_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      space_idx = bbm_pkg::SPACE_DMA_IDX;
      space_has_bit = 1'b1;
      if (!internal_bus && tt_style_q)
      begin
         if (ext_kind_i == bbm_pkg::KIND_ACK)
         begin
            space_idx = bbm_pkg::SPACE_ACK_IDX;
         end
         else if ((ext_kind_i == bbm_pkg::KIND_NORMAL) && (ext_mod_i != bbm_pkg::MOD_NONE))
         begin
            space_idx = {1'b0, ext_mod_i};
         end
         else
         begin
            space_has_bit = 1'b0;
         end
      end
      else if (!w_fc[3])
      begin
         space_idx = {1'b0, w_fc[2:0]};
      end
   end

   assign space_ok = !(space_has_bit && space_exclude_bits[space_idx]);
   assign match = ctrl_valid && w_cyc && dir_ok && space_ok && addr_term && width_ok;

   // ----------------------------------------------------------------
   // Break request
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         break_q <= 1'b0;
      end
      else
      begin
         break_q <= match;
      end
   end

   assign break_request_o = break_q;

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   logic req;
   logic wr_req;
   logic [31:0] wmask;

   assign req = wb_cyc_i && wb_stb_i && (bus_q == bbm_pkg::BBM_BUS_IDLE);
   assign wr_req = req && wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // One request per strobe; ack drops in the cycle after it is given
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_q <= bbm_pkg::BBM_BUS_IDLE;
         ack_q <= 1'b0;
      end
      else
      begin
         case (bus_q)
            bbm_pkg::BBM_BUS_IDLE:
            begin
               ack_q <= req;
               if (req)
               begin
                  bus_q <= bbm_pkg::BBM_BUS_ACK;
               end
            end
            default:
            begin
               ack_q <= 1'b0;
               bus_q <= bbm_pkg::BBM_BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         match_address_reg_q <= bbm_pkg::ADDR_RESET;
      end
      else if (wr_req && (wb_adr_i == bbm_pkg::ADDR_OFS))
      begin
         match_address_reg_q <= (match_address_reg_q & ~wmask) | (wb_dat_i & wmask);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         match_control_reg_q <= bbm_pkg::CTRL_RESET;
      end
      else if (wr_req && (wb_adr_i == bbm_pkg::CTRL_OFS))
      begin
         match_control_reg_q <= ((match_control_reg_q & ~wmask) | (wb_dat_i & wmask)) & bbm_pkg::CTRL_WR_MASK;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tt_style_q <= bbm_pkg::OPT_RESET;
      end
      else if (wr_req && (wb_adr_i == bbm_pkg::OPTION_OFS) && wb_sel_i[0])
      begin
         tt_style_q <= wb_dat_i[bbm_pkg::OPT_TT_BIT];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (req && !wb_we_i)
      begin
         case (wb_adr_i)
            bbm_pkg::ADDR_OFS: rdata_q <= match_address_reg_q;
            bbm_pkg::CTRL_OFS: rdata_q <= match_control_reg_q;
            bbm_pkg::IRQ_STAT_OFS: rdata_q <= {31'h0, irq_stat_q};
            bbm_pkg::IRQ_MASK_OFS: rdata_q <= {31'h0, irq_mask_q};
            bbm_pkg::OPTION_OFS: rdata_q <= {31'h0, tt_style_q};
            bbm_pkg::LIVE_OFS: rdata_q <= {31'h0, break_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_dat_o = rdata_q;
   assign wb_ack_o = ack_q;

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   logic break_rise;
   logic clr_hit;

   assign break_rise = match && !break_q;
   assign clr_hit = wr_req && (wb_adr_i == bbm_pkg::IRQ_STAT_OFS) && wb_sel_i[0] && wb_dat_i[bbm_pkg::IRQ_BREAK_BIT];

   // A new break in the clearing cycle survives the clear
   always_comb
   begin
      irq_stat_d = break_rise || (irq_stat_q && !clr_hit);
      irq_mask_d = irq_mask_q;
      if (wr_req && (wb_adr_i == bbm_pkg::IRQ_MASK_OFS) && wb_sel_i[0])
      begin
         irq_mask_d = wb_dat_i[bbm_pkg::IRQ_BREAK_BIT];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_stat_q <= bbm_pkg::IRQ_RESET;
         irq_mask_q <= bbm_pkg::IRQ_RESET;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         irq_q <= irq_stat_d && irq_mask_d;
      end
   end

   assign irq_o = irq_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   valid_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) !ctrl_valid |=> !break_q)
      else $error("break without valid bit");
   read_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cycle_dir_sel == bbm_pkg::DIR_READ) && w_write |=> !break_q)
      else $error("break on write in read-only mode");
   write_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cycle_dir_sel == bbm_pkg::DIR_WRITE) && !w_write |=> !break_q)
      else $error("break on read in write-only mode");
   cycle_end_a: assert property (@(posedge clk_i) disable iff (rst_i) $fell(w_cyc) |=> !break_q)
      else $error("break outlives cycle");
   exact_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (block_size_sel == bbm_pkg::BLK_FULL) && !ignore_eff && (w_width != width_code) |=> !break_q)
      else $error("break with width mismatch");
   offset_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (block_size_sel == bbm_pkg::BLK_FULL) && ignore_eff && (match_address_reg_q[1:0] == 2'h0)
      && (w_addr[1:0] != 2'h0) |=> !break_q)
      else $error("offset zero hit from other offset");
   invert_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (block_size_sel != bbm_pkg::BLK_FULL) && invert_block_match && addr_hit |=> !break_q)
      else $error("inverted match inside block");
   space_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      internal_bus && w_fc[3] && space_exclude_bits[8] |=> !break_q)
      else $error("break in excluded space");
   full_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_valid && w_cyc && (cycle_dir_sel == bbm_pkg::DIR_BOTH) && (space_exclude_bits == 9'h000)
      && (block_size_sel == bbm_pkg::BLK_FULL) && !ignore_eff && (w_addr == match_address_reg_q)
      && (w_width == width_code) |=> break_q)
      else $error("missed exact breakpoint");
   reset_clear_a: assert property (@(posedge clk_i) rst_i |=> (match_control_reg_q == 32'h0000_0000))
      else $error("control not cleared by reset");
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_q |=> !ack_q)
      else $error("ack held two cycles");
endmodule // bbm_top

/* testbench/bbm_bus_model.sv */
// Purpose: Bus master model that issues watched bus cycles.
// Assumes: Break request is registered, one clock behind the cycle.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
module bbm_bus_model (
   input wire logic clk_i, // System clock
   input wire logic brk_i, // Break request from the matcher
   output logic int_cyc_o, // Internal cycle active
   output logic [31:0] int_addr_o, // Internal address
   output logic int_write_o, // Internal write
   output logic [1:0] int_width_o, // Internal width code
   output logic [3:0] int_fc_o, // Internal function code
   output logic ext_cyc_o, // External cycle active
   output logic [31:0] ext_addr_o, // External address
   output logic ext_write_o, // External write
   output logic [1:0] ext_width_o, // External width code
   output logic [3:0] ext_fc_o, // External function code
   output logic [1:0] ext_kind_o, // Transfer kind
   output logic [2:0] ext_mod_o // Transfer modifier
);
   initial
   begin
      {int_cyc_o, int_addr_o, int_write_o, int_width_o, int_fc_o} = '0;
      {ext_cyc_o, ext_addr_o, ext_write_o, ext_width_o, ext_fc_o, ext_kind_o, ext_mod_o} = '0;
   end

   // Len 1 is a prompt cycle, larger values a slow one
   task automatic issue(input logic ext, input logic [31:0] a, input logic wr, input logic [1:0] w,
                        input logic [3:0] fc, input logic [1:0] k, input logic [2:0] m, input int len,
                        output logic hit, output logic late);
      @(posedge clk_i);
      if (ext)
         {ext_cyc_o, ext_addr_o, ext_write_o, ext_width_o, ext_fc_o, ext_kind_o, ext_mod_o} <= {1'b1, a, wr, w, fc, k, m};
      else
         {int_cyc_o, int_addr_o, int_write_o, int_width_o, int_fc_o} <= {1'b1, a, wr, w, fc};
      hit = 1'b0;
      repeat (len)
      begin
         @(posedge clk_i);
         #1 hit = hit | brk_i;
      end
      if (ext)
         {ext_cyc_o, ext_addr_o, ext_write_o, ext_width_o, ext_fc_o, ext_kind_o, ext_mod_o} <= {1'b0, ~a, ~wr, ~w, ~fc, ~k, ~m};
      else
         {int_cyc_o, int_addr_o, int_write_o, int_width_o, int_fc_o} <= {1'b0, ~a, ~wr, ~w, ~fc};
      // First edge after release already must show the drop
      @(posedge clk_i);
      #1 late = brk_i;
   endtask
endmodule // bbm_bus_model

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the breakpoint matcher.
// Assumes: Wishbone answer one cycle after the request is taken.
// Notes: Expected break computed by a reference of the match rules.
`timescale 1ns/1ps
module tb_top;
   // Overlap decode indexed by programmed low bits, cycle low bits, width
   localparam logic [63:0] OVL = 64'hfd91_0fd9_fffd_000f;
   logic clk_i = 1'b0;
   logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, break_request_o, irq_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic int_cyc_i, int_write_i, ext_cyc_i, ext_write_i, hit, late, expv, opt;
   logic [31:0] int_addr_i, ext_addr_i;
   logic [1:0] int_width_i, ext_width_i, ext_kind_i;
   logic [3:0] int_fc_i, ext_fc_i;
   logic [2:0] ext_mod_i;
   int bad_count, compares, ln;

   always #12.5 clk_i = ~clk_i;

   bbm_top i_bbm_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .int_cyc_i, .int_addr_i, .int_write_i, .int_width_i, .int_fc_i, .ext_cyc_i,
      .ext_addr_i, .ext_write_i, .ext_width_i, .ext_fc_i, .ext_kind_i, .ext_mod_i, .break_request_o, .irq_o);

   bbm_bus_model i_bbm_bus_model (.clk_i(clk_i), .brk_i(break_request_o), .int_cyc_o(int_cyc_i),
      .int_addr_o(int_addr_i), .int_write_o(int_write_i), .int_width_o(int_width_i), .int_fc_o(int_fc_i),
      .ext_cyc_o(ext_cyc_i), .ext_addr_o(ext_addr_i), .ext_write_o(ext_write_i), .ext_width_o(ext_width_i),
      .ext_fc_o(ext_fc_i), .ext_kind_o(ext_kind_i), .ext_mod_o(ext_mod_i));

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want)
      begin
         bad_count++;
         $display("ERROR %0t: seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hf, dat};
      for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
         @(posedge clk_i);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (n == 20)
      begin
         bad_count++;
         end_sim();
      end
   endtask

   function automatic logic rmatch(logic [31:0] c, ba, a, logic wr, logic [1:0] w, logic [3:0] fc,
                                   logic [1:0] k, logic [2:0] m);
      logic [31:0] msk;
      logic ok;
      int idx;
      msk = c[11:10] == 1 ? 32'hffff_f800 : c[11:10] == 2 ? 32'hffff_e000 :
            c[11:10] == 3 ? 32'hffff_8000 : 32'hffff_ffff;
      // Ignored width leaves the low two bits to the overlap table
      if (c[18] || c[15])
         msk = msk & 32'hffff_fffc;
      ok = ((a & msk) == (ba & msk)) ^ (c[12] && c[11:10] != 0);
      if (c[11:10] == 0)
         ok = ok & ((c[15] || c[18]) ? OVL[{ba[1:0], a[1:0], w}] : (w == c[14:13]));
      ok = ok & ((c[17:16] == 2) || (c[17:16] == 0 && !wr) || (c[17:16] == 1 && wr));
      idx = fc[3] ? 8 : int'(fc[2:0]);
      if (c[18] && opt)
         idx = k == 3 ? 7 : (k == 0 && m != 7) ? int'(m) : 9;
      return c[0] && ok && (idx == 9 || !c[1 + idx]);
   endfunction

   task automatic run(input logic [31:0] c, ba, a, input logic wr, input logic [1:0] w, input logic [3:0] fc,
                      input logic [1:0] k, input logic [2:0] m);
      wb(1'b1, 8'h00, ba);
      wb(1'b1, 8'h04, c);
      ln = 4 - ln;
      i_bbm_bus_model.issue(c[18], a, wr, w, fc, k, m, ln, hit, late);
      expv = rmatch(c, ba, a, wr, w, fc, k, m);
      chk(late, 1'b0);
   endtask

   initial
   begin
      logic [31:0] dl;
      logic [8:0] ex;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {bad_count, compares, ln, opt} = {32'd0, 32'd0, 32'd1, 1'b0};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      // Offset 0x18 is unmapped and must read zero
      for (int i = 0; i < 7; i++)
      begin
         wb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, 32'h0);
      end
      wb(1'b1, 8'h18, 32'hffff_ffff);
      wb(1'b1, 8'h04, 32'hffff_ffff);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h000f_ffff);
      wb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 8; i++)
      begin
         run({14'h0, i[2:1], 16'h1}, 32'h1000, 32'h1000, i[0], 2'h0, 4'h1, 2'h0, 3'h0);
         chk(hit, expv);
      end
      run(32'h0002_0000, 32'h1000, 32'h1000, 1'b1, 2'h0, 4'h1, 2'h0, 3'h0);
      chk(hit, 1'b0);
      $display("test direction done");
      for (int i = 0; i < 64; i++)
      begin
         run({16'h2, 1'b0, i[3:2], 13'h1}, 32'h1002, {30'h400, i[5:4]}, 1'b0, i[1:0], 4'h1, 2'h0, 3'h0);
         chk(hit, expv);
      end
      for (int i = 0; i < 128; i++)
      begin
         run({13'h0, i[6], 2'h2, ~i[6], 15'h1}, {30'h800, i[5:4]}, {30'h800, i[3:2]}, 1'b0, i[1:0], 4'h1,
             2'h0, 3'h0);
         chk(hit, expv);
      end
      $display("test width done");
      for (int i = 0; i < 32; i++)
      begin
         dl = 32'h400 << {i[4:3], 1'b0};
         run({16'h2, 3'h0, i[2], i[1:0], 10'h1}, 32'h1234_5678, 32'h1234_5678 ^ dl, 1'b1, i[1:0], 4'h1,
             2'h0, 3'h0);
         chk(hit, expv);
      end
      $display("test block done");
      for (int i = 0; i < 32; i++)
      begin
         ex = 9'h1 << (i[3] ? 4'h8 : {1'b0, i[2:0]});
         if (!i[4])
            ex = ~ex;
         run({16'h2, 6'h0, ex, 1'b1}, 32'h40, 32'h40, 1'b1, 2'h0, i[3:0], 2'h0, 3'h0);
         chk(hit, expv);
      end
      wb(1'b1, 8'h10, 32'h1);
      opt = 1'b1;
      for (int i = 0; i < 32; i++)
      begin
         run({13'h0, 1'b1, 2'h2, 6'h0, 9'h1ff, 1'b1}, 32'h40, 32'h40, 1'b1, 2'h0, 4'hf, i[4:3], i[2:0]);
         chk(hit, expv);
      end
      wb(1'b1, 8'h10, 32'h0);
      opt = 1'b0;
      $display("test spaces done");
      // Sticky status, masked and unmasked
      wb(1'b1, 8'h08, 32'h1);
      wb(1'b1, 8'h0c, 32'h1);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      chk(irq_o, 1'b0);
      run(32'h0002_0001, 32'h80, 32'h80, 1'b0, 2'h0, 4'h1, 2'h0, 3'h0);
      chk(irq_o, 1'b1);
      wb(1'b1, 8'h08, 32'h1);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      chk(irq_o, 1'b0);
      wb(1'b1, 8'h0c, 32'h0);
      run(32'h0002_0001, 32'h80, 32'h80, 1'b0, 2'h0, 4'h1, 2'h0, 3'h0);
      chk(irq_o, 1'b0);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h1);
      $display("test interrupt done");
      // Mid-run reset must clear a live control word
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      $display("test reset done");
      end_sim();
   end
endmodule // tb_top
